/* File: rxaec_pkg.sv */
package rxaec_pkg;
   localparam int          RXAEC_ADDR_W       = 6;
   localparam int          RXAEC_CNT_W        = 16;
   localparam logic [5:0]  RXAEC_OFF_COUNT    = 6'h00;
   localparam logic [5:0]  RXAEC_OFF_CLR      = 6'h04;
   localparam logic [5:0]  RXAEC_OFF_SET      = 6'h08;
   localparam logic [5:0]  RXAEC_OFF_INV      = 6'h0C;
   localparam logic [5:0]  RXAEC_OFF_FRAME    = 6'h10;
   localparam logic [15:0] RXAEC_COUNT_RESET  = 16'h0000;
   localparam logic [1:0]  RXAEC_RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RXAEC_RESP_SLVERR  = 2'h2;
   localparam int          RXAEC_BYTE_BITS    = 8;

   typedef enum logic [1:0]
   {
      RXAEC_OP_WRITE  = 2'h0,
      RXAEC_OP_CLEAR  = 2'h1,
      RXAEC_OP_SET    = 2'h2,
      RXAEC_OP_INVERT = 2'h3
   } rxaec_op_t;

   typedef struct packed
   {
      logic        valid;
      logic        fcs_bad;
      logic [2:0]  bit_residue;
      logic        is_tx;
   } rxaec_frame_t;

   typedef struct packed
   {
      logic                    en;
      rxaec_op_t               op;
      logic [15:0]             data;
      logic [1:0]              strb;
   } rxaec_wr_t;
endpackage

/* File: rxaec_counter.sv */
`timescale 1ns/1ps
`default_nettype none
module rxaec_counter
   import rxaec_pkg::*;
#(
   parameter int CNT_W = RXAEC_CNT_W
)
(
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   input  wire logic             inc_in,
   input  wire logic             rd_clear_in,
   input  wire rxaec_wr_t        wr_in,
   output var  logic [CNT_W-1:0] count_out
);
   logic [CNT_W-1:0] base;
   logic [CNT_W-1:0] mask;
   logic [CNT_W-1:0] next_count;

   always_comb
   begin
      mask = {CNT_W{1'b0}};
      for (int i = 0; i < CNT_W; i++)
      begin
         mask[i] = wr_in.strb[i / RXAEC_BYTE_BITS];
      end
      base = count_out;
      if (rd_clear_in)
      begin
         base = {CNT_W{1'b0}};
      end
      if (wr_in.en)
      begin
         unique case (wr_in.op)
            RXAEC_OP_WRITE:  base = (base & ~mask) | (wr_in.data & mask);
            RXAEC_OP_CLEAR:  base = base & ~(wr_in.data & mask);
            RXAEC_OP_SET:    base = base | (wr_in.data & mask);
            RXAEC_OP_INVERT: base = base ^ (wr_in.data & mask);
         endcase
      end
      // The increment is applied after any clear so no event is lost.
      next_count = base + {{(CNT_W-1){1'b0}}, inc_in};
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         count_out <= CNT_W'(RXAEC_COUNT_RESET);
      end
      else
      begin
         count_out <= next_count;
      end
   end
endmodule
`default_nettype wire

/* File: rxaec_top.sv */
// Operation
// - 16-bit readable writable count, zero at reset
// - Add one per flagged misaligned frame
// - Misaligned means bad FCS and a nonzero bit residue (1 to 7 leftover bits)
// - Only receive frames add to the count
// - Read of offset 0x00 clears unless byte lanes 0/1 off
// - Upper sixteen bits read zero, ignore writes
//
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module rxaec_top
   import rxaec_pkg::*;
(
   input  wire logic                    REF_CLK_IN,
   input  wire logic                    RST_IN,
   input  wire rxaec_frame_t            FRAME_IN,
   input  wire logic [RXAEC_ADDR_W-1:0] S_AXI_AWADDR_IN,
   input  wire logic                    S_AXI_AWVALID_IN,
   output var  logic                    S_AXI_AWREADY_OUT,
   input  wire logic [31:0]             S_AXI_WDATA_IN,
   input  wire logic [3:0]              S_AXI_WSTRB_IN,
   input  wire logic                    S_AXI_WVALID_IN,
   output var  logic                    S_AXI_WREADY_OUT,
   output var  logic [1:0]              S_AXI_BRESP_OUT,
   output var  logic                    S_AXI_BVALID_OUT,
   input  wire logic                    S_AXI_BREADY_IN,
   input  wire logic [RXAEC_ADDR_W-1:0] S_AXI_ARADDR_IN,
   input  wire logic                    S_AXI_ARVALID_IN,
   output var  logic                    S_AXI_ARREADY_OUT,
   input  wire logic [3:0]              S_AXI_ARSTRB_IN,
   output var  logic [31:0]             S_AXI_RDATA_OUT,
   output var  logic [1:0]              S_AXI_RRESP_OUT,
   output var  logic                    S_AXI_RVALID_OUT,
   input  wire logic                    S_AXI_RREADY_IN,
   output var  logic [RXAEC_CNT_W-1:0]  COUNT_OUT
);
   logic                    aw_held;
   logic [RXAEC_ADDR_W-1:0] aw_addr;
   logic                    w_held;
   logic [31:0]             w_data;
   logic [3:0]              w_strb;
   logic                    do_write;
   logic                    wr_hit;
   logic                    do_read;
   logic                    rd_clear;
   logic                    frame_misaligned;
   logic [RXAEC_CNT_W-1:0]  count;
   rxaec_wr_t               wr;

   function automatic logic rxaec_is_reg(input logic [RXAEC_ADDR_W-1:0] a);
      rxaec_is_reg = (a == RXAEC_OFF_COUNT) || (a == RXAEC_OFF_CLR)
                  || (a == RXAEC_OFF_SET) || (a == RXAEC_OFF_INV);
   endfunction

   // Misaligned: bad FCS on a receive frame with leftover bits.
   assign frame_misaligned = FRAME_IN.valid && !FRAME_IN.is_tx
                          && FRAME_IN.fcs_bad
                          && (FRAME_IN.bit_residue != 3'h0);

   always_ff @(posedge REF_CLK_IN)
   begin
      if (RST_IN)
      begin
         aw_held <= 1'b0;
         aw_addr <= {RXAEC_ADDR_W{1'b0}};
      end
      else if (do_write)
      begin
         aw_held <= 1'b0;
      end
      else if (S_AXI_AWVALID_IN && !aw_held)
      begin
         aw_held <= 1'b1;
         aw_addr <= S_AXI_AWADDR_IN;
      end
   end

   always_ff @(posedge REF_CLK_IN)
   begin
      if (RST_IN)
      begin
         w_held <= 1'b0;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
      end
      else if (do_write)
      begin
         w_held <= 1'b0;
      end
      else if (S_AXI_WVALID_IN && !w_held)
      begin
         w_held <= 1'b1;
         w_data <= S_AXI_WDATA_IN;
         w_strb <= S_AXI_WSTRB_IN;
      end
   end

   assign do_write = aw_held && w_held && !S_AXI_BVALID_OUT;
   assign wr_hit   = rxaec_is_reg({aw_addr[RXAEC_ADDR_W-1:2], 2'b00});

   always_comb
   begin
      wr.en   = do_write && wr_hit;
      wr.data = w_data[RXAEC_CNT_W-1:0];
      wr.strb = w_strb[1:0];
      unique case (aw_addr[3:2])
         2'h1:    wr.op = RXAEC_OP_CLEAR;
         2'h2:    wr.op = RXAEC_OP_SET;
         2'h3:    wr.op = RXAEC_OP_INVERT;
         default: wr.op = RXAEC_OP_WRITE;
      endcase
   end

   always_ff @(posedge REF_CLK_IN)
   begin
      if (RST_IN)
      begin
         S_AXI_AWREADY_OUT <= 1'b0;
         S_AXI_WREADY_OUT  <= 1'b0;
         S_AXI_BVALID_OUT  <= 1'b0;
         S_AXI_BRESP_OUT   <= RXAEC_RESP_OKAY;
      end
      else
      begin
         S_AXI_AWREADY_OUT <= !aw_held && !S_AXI_AWREADY_OUT
                           && S_AXI_AWVALID_IN;
         S_AXI_WREADY_OUT  <= !w_held && !S_AXI_WREADY_OUT
                           && S_AXI_WVALID_IN;
         if (do_write)
         begin
            S_AXI_BVALID_OUT <= 1'b1;
            S_AXI_BRESP_OUT  <= wr_hit ? RXAEC_RESP_OKAY : RXAEC_RESP_SLVERR;
         end
         else if (S_AXI_BREADY_IN)
         begin
            S_AXI_BVALID_OUT <= 1'b0;
         end
      end
   end

   assign do_read  = S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;
   assign rd_clear = do_read
                  && ({S_AXI_ARADDR_IN[RXAEC_ADDR_W-1:2], 2'b00}
                      == RXAEC_OFF_COUNT)
                  && (S_AXI_ARSTRB_IN[1:0] != 2'b00);

   always_ff @(posedge REF_CLK_IN)
   begin
      if (RST_IN)
      begin
         S_AXI_ARREADY_OUT <= 1'b0;
         S_AXI_RVALID_OUT  <= 1'b0;
         S_AXI_RDATA_OUT   <= 32'h00000000;
         S_AXI_RRESP_OUT   <= RXAEC_RESP_OKAY;
      end
      else
      begin
         S_AXI_ARREADY_OUT <= !S_AXI_ARREADY_OUT && !S_AXI_RVALID_OUT
                           && S_AXI_ARVALID_IN;
         if (do_read)
         begin
            S_AXI_RVALID_OUT <= 1'b1;
            unique case ({S_AXI_ARADDR_IN[RXAEC_ADDR_W-1:2], 2'b00})
               RXAEC_OFF_COUNT, RXAEC_OFF_CLR, RXAEC_OFF_SET, RXAEC_OFF_INV:
               begin
                  S_AXI_RDATA_OUT <= {16'h0000, count};
                  S_AXI_RRESP_OUT <= RXAEC_RESP_OKAY;
               end
               default:
               begin
                  S_AXI_RDATA_OUT <= 32'h00000000;
                  S_AXI_RRESP_OUT <= RXAEC_RESP_SLVERR;
               end
            endcase
         end
         else if (S_AXI_RREADY_IN)
         begin
            S_AXI_RVALID_OUT <= 1'b0;
         end
      end
   end

   rxaec_counter #(
      .CNT_W (RXAEC_CNT_W)
   ) u_counter (
      .clk_in      (REF_CLK_IN),
      .rst_in      (RST_IN),
      .inc_in      (frame_misaligned),
      .rd_clear_in (rd_clear),
      .wr_in       (wr),
      .count_out   (count)
   );

   always_ff @(posedge REF_CLK_IN)
   begin
      if (RST_IN)
      begin
         COUNT_OUT <= RXAEC_COUNT_RESET;
      end
      else
      begin
         COUNT_OUT <= count;
      end
   end
endmodule
`default_nettype wire

/* File: rxaec_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module rxaec_monitor
   import rxaec_pkg::*;
(
   input wire logic         REF_CLK_IN,
   input wire logic         RST_IN,
   input wire rxaec_frame_t FRAME_IN,
   input wire logic [5:0]   S_AXI_ARADDR_IN,
   input wire logic         S_AXI_ARVALID_IN,
   input wire logic         S_AXI_ARREADY_OUT,
   input wire logic [3:0]   S_AXI_ARSTRB_IN,
   input wire logic [31:0]  S_AXI_RDATA_OUT,
   input wire logic         S_AXI_RVALID_OUT,
   input wire logic [15:0]  COUNT_OUT
);
   wire good = FRAME_IN.valid && FRAME_IN.fcs_bad && !FRAME_IN.is_tx
      && FRAME_IN.bit_residue != 3'h0;
   wire clr = S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT
      && {S_AXI_ARADDR_IN[5:2], 2'b00} == RXAEC_OFF_COUNT;
   wire lanes = S_AXI_ARSTRB_IN[1:0] != 2'h0;
   default clocking @(posedge REF_CLK_IN); endclocking
   default disable iff (RST_IN);
   reset_zero_a: assert property (disable iff (1'b0)
      RST_IN |=> COUNT_OUT == 16'h0000) else $error("count not reset");
   frame_inc_a: assert property (good && !S_AXI_ARVALID_IN |=>
      ##1 COUNT_OUT - $past(COUNT_OUT) == 16'h0001) else $error("missed");
   no_count_a: assert property (FRAME_IN.valid && !good &&
      !S_AXI_ARVALID_IN |=> ##1 $stable(COUNT_OUT)) else $error("stray");
   read_clear_a: assert property (clr && lanes && !good |=> ##1
      COUNT_OUT == 16'h0000) else $error("read did not clear");
   keep_read_a: assert property (clr && !lanes && !good |=> ##1
      $stable(COUNT_OUT)) else $error("read cleared count");
   clear_inc_a: assert property (clr && lanes && good |=> ##1
      COUNT_OUT == 16'h0001) else $error("increment lost");
   upper_zero_a: assert property (S_AXI_RVALID_OUT |->
      S_AXI_RDATA_OUT[31:16] == 16'h0000) else $error("upper bits set");
endmodule
bind rxaec_top rxaec_monitor rxaec_monitor_inst (.REF_CLK_IN, .RST_IN,
   .FRAME_IN, .S_AXI_ARADDR_IN, .S_AXI_ARVALID_IN, .S_AXI_ARREADY_OUT,
   .S_AXI_ARSTRB_IN, .S_AXI_RDATA_OUT, .S_AXI_RVALID_OUT, .COUNT_OUT);
`default_nettype wire

/* File: test_rx_alignment_error_counter.sv */
`timescale 1ns/1ps
`default_nettype none
module test_rx_alignment_error_counter
   import rxaec_pkg::*;
();
   logic         clk = 1'b0;
   logic         rst, awvalid, wvalid, bready, arvalid, rready;
   logic         awready, wready, bvalid, arready, rvalid;
   logic [1:0]   bresp, rresp;
   logic [3:0]   wstrb, arstrb;
   logic [5:0]   awaddr, araddr;
   logic [15:0]  count;
   logic [31:0]  wdata, rdata;
   rxaec_frame_t frame;
   int           n_errors = 0, checks = 0, cycles = 0;
   rxaec_top rxaec_top_inst (.REF_CLK_IN(clk), .RST_IN(rst),
      .FRAME_IN(frame), .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid),
      .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata),
      .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid),
      .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp),
      .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
      .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
      .S_AXI_ARREADY_OUT(arready), .S_AXI_ARSTRB_IN(arstrb),
      .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
      .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready), .COUNT_OUT(count));
   initial forever #2.5 clk = ~clk;
   always @(posedge clk) if (++cycles > 3000) close_out(1);
   task automatic close_out(input int late);
      n_errors += late;
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] got, exp);
      checks++;
      if (got !== exp)
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      n_errors += int'(got !== exp);
   endtask
   task automatic wr_at(input logic [5:0] a, input logic [31:0] d,
                        input logic [3:0] s, input logic [1:0] resp);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      {awvalid, wvalid, bready} <= 3'h7;
      do
      begin
         @(posedge clk);
         awvalid <= awvalid && !awready;
         wvalid <= wvalid && !wready;
      end
      while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk("write response", {30'h0, bresp}, {30'h0, resp});
      @(posedge clk);
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      wr_at(a, d, 4'hF, RXAEC_RESP_OKAY);
   endtask
   task automatic rd_at(input logic [5:0] a, input logic [3:0] s,
                        input logic [31:0] exp, input logic [1:0] resp);
      araddr <= a;
      arstrb <= s;
      {arvalid, rready} <= 2'h3;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk("read data", rdata, exp);
      chk("read response", {30'h0, rresp}, {30'h0, resp});
      @(posedge clk);
   endtask
   task automatic rd(input logic [3:0] s, input logic [31:0] exp);
      rd_at(RXAEC_OFF_COUNT, s, exp, RXAEC_RESP_OKAY);
   endtask
   task automatic fr(input logic [2:0] res, input logic bad, tx);
      frame <= '{1'b1, bad, res, tx};
      @(posedge clk);
      frame <= '0;
      repeat (3) @(posedge clk);
   endtask
   initial
   begin
      {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
      {awaddr, araddr, wdata} = 44'h0;
      {wstrb, arstrb} = 8'hFF;
      frame = '0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(4'hF, 32'h0);
      for (int r = 1; r < 8; r++)
         fr(3'(r), 1'b1, 1'b0);
      fr(3'h3, 1'b0, 1'b0);
      fr(3'h0, 1'b1, 1'b0);
      fr(3'h5, 1'b1, 1'b1);
      chk("count port", {16'h0, count}, 32'h7);
      rd(4'hC, 32'h7);
      rd(4'h2, 32'h7);
      rd(4'hF, 32'h0);
      wr(RXAEC_OFF_COUNT, 32'hFFFF_A5C3);
      wr(RXAEC_OFF_CLR, 32'h00C3);
      wr(RXAEC_OFF_SET, 32'h000F);
      wr(RXAEC_OFF_INV, 32'hFFFF);
      rd(4'hF, 32'h5AF0);
      wr(RXAEC_OFF_COUNT, 32'hFFFF);
      fr(3'h7, 1'b1, 1'b0);
      rd(4'hF, 32'h0);
      fork
         rd(4'hF, 32'h0);
         begin
            @(posedge clk);
            fr(3'h1, 1'b1, 1'b0);
         end
      join
      rd(4'hF, 32'h1);
      wr_at(RXAEC_OFF_COUNT, 32'h0000_BEEF, 4'h2, RXAEC_RESP_OKAY);
      rd_at(RXAEC_OFF_SET, 4'hF, 32'hBE00, RXAEC_RESP_OKAY);
      rd(4'hF, 32'hBE00);
      wr_at(RXAEC_OFF_FRAME, 32'h00FF, 4'hF, RXAEC_RESP_SLVERR);
      rd_at(RXAEC_OFF_FRAME, 4'hF, 32'h0, RXAEC_RESP_SLVERR);
      rd(4'hF, 32'h0);
      close_out(0);
   end
endmodule
`default_nettype wire
